// *** dv/aer_uncorrectable_error_log_asserts.sv ***
// Port checker for the uncorrectable error log.
// Assumes the block's own ports only; bound below.
`timescale 1ns/1ps
module aer_log_checker
	import aer_pkg::*;
(
	input wire logic        I_CORE_CLK,
	input wire logic        I_RST_N,
	input wire cfg_req_t    I_CFG_REQ,
	input wire err_events_t I_ERR_EVENTS,
	input wire logic        I_SURPRISE_LOSS_REPORT_CAPABLE,
	input wire logic        O_CFG_ACK,
	input wire logic        O_CFG_HIT,
	input wire logic [31:0] O_CFG_RDATA,
	input wire logic        O_REPORT_FATAL,
	input wire logic        O_REPORT_NONFATAL
);
	// ==========
	// Properties
	default clocking @(posedge I_CORE_CLK); endclocking
	default disable iff (!I_RST_N);
	wire logic [11:0] ad  = I_CFG_REQ.addr;
	wire logic        rd  = I_CFG_REQ.req && !I_CFG_REQ.wr;
	wire logic        hdr = rd && ad == OFS_CAP_HEADER;
	wire logic        sm  = rd && (ad == OFS_UE_STATUS || ad == OFS_UE_MASK);
	wire logic        rep = O_REPORT_FATAL || O_REPORT_NONFATAL;
	wire logic        unm = I_CFG_REQ.req && !(ad inside {OFS_CAP_HEADER,
		OFS_UE_STATUS, OFS_UE_MASK, OFS_UE_SEVER});
	property p_cid; hdr |=> O_CFG_RDATA[15:0] == CAP_ID_VALUE; endproperty
	a_cid: assert property (p_cid) else $error("cap id");
	property p_ver; hdr |=> O_CFG_RDATA[19:16] == CAP_VER_VALUE; endproperty
	a_ver: assert property (p_ver) else $error("cap ver");
	property p_obs; rd && ad == OFS_UE_STATUS |=> !O_CFG_RDATA[0]; endproperty
	a_obs: assert property (p_obs) else $error("obsolete bit");
	property p_cto; sm |=> !O_CFG_RDATA[14]; endproperty
	a_cto: assert property (p_cto) else $error("timeout bit");
	property p_cab; sm |=> !O_CFG_RDATA[15]; endproperty
	a_cab: assert property (p_cab) else $error("abort bit");
	property p_rsv; sm |=> (O_CFG_RDATA & ~IMPL_BITS) == ZERO_WORD; endproperty
	a_rsv: assert property (p_rsv) else $error("reserved bits");
	property p_unm; unm |=> O_CFG_ACK && !O_CFG_HIT && O_CFG_RDATA == 0;
	endproperty
	a_unm: assert property (p_unm) else $error("unmapped");
	property p_qui; I_ERR_EVENTS == 9'h000 |=> !rep; endproperty
	a_qui: assert property (p_qui) else $error("report no event");
	property p_sdn; I_ERR_EVENTS == 9'h080 && !I_SURPRISE_LOSS_REPORT_CAPABLE
		|=> !rep; endproperty
	a_sdn: assert property (p_sdn) else $error("surprise report");
	c_fat: cover property (O_REPORT_FATAL);
	c_nft: cover property (O_REPORT_NONFATAL);
	c_unm: cover property (unm);
endmodule : aer_log_checker
bind aer_uncorrectable_error_log aer_log_checker aer_log_checker_inst (.*);

// *** dv/rc_cfg_model.sv ***
// Root complex side: one configuration request at a time.
// Assumes a one-cycle answer; drives at the falling edge.
`timescale 1ns/1ps
module rc_cfg_model
	import aer_pkg::*;
(
	input  wire logic        i_clk,
	input  wire logic        i_ack,
	input  wire logic        i_hit,
	input  wire logic [31:0] i_rdata,
	output cfg_req_t         o_req
);
	initial o_req = '0;
	// Software clears logged errors by writing ones; idle bus shows inverse.
	task automatic xfer(input logic w, input logic [11:0] a,
		input logic [31:0] d, input int g, output logic [31:0] r,
		output logic [1:0] ah);
		// One falling edge always passes first, so calls in a row never
		// drive the request twice in one time step.
		repeat (g + 1) @(negedge i_clk);
		o_req = '{1'b1, w, a, 4'hf, d};
		@(negedge i_clk);
		o_req = '{1'b0, ~w, ~a, 4'h0, ~d};
		r = i_rdata;
		ah = {i_ack, i_hit};
	endtask : xfer
endmodule : rc_cfg_model

// *** dv/tb_aer_uncorrectable_error_log.sv ***
// Self-checking bench for the uncorrectable error log.
// Assumes the root complex model for all register traffic.
`timescale 1ns/1ps
module tb_aer_uncorrectable_error_log;
	import aer_pkg::*;
	localparam logic [31:0] hdr0 = {NEXT_PTR_RESET, CAP_VER_VALUE,
		CAP_ID_VALUE};
	logic        clk = 1'b0, rst_n = 1'b0, cap = 1'b1, unl = 1'b0;
	err_events_t ev = '0;
	cfg_req_t    req;
	logic        ack, hit, fat, nft;
	logic [31:0] rdata, rd, e, sv = SEVER_RESET, lf = 32'h2fcb;
	logic [1:0]  ah;
	int          mismatches = 0, n_checks = 0, cyc = 0;
	int          pos[9] = '{4, 5, 12, 13, 16, 17, 18, 19, 20};
	always #5 clk = ~clk;
	aer_uncorrectable_error_log aer_uncorrectable_error_log_inst (
		.I_CORE_CLK(clk), .I_RST_N(rst_n), .I_CFG_REQ(req),
		.I_ERR_EVENTS(ev), .I_SURPRISE_LOSS_REPORT_CAPABLE(cap),
		.I_NEXT_PTR_UNLOCK(unl), .O_CFG_ACK(ack), .O_CFG_HIT(hit),
		.O_CFG_RDATA(rdata), .O_REPORT_FATAL(fat), .O_REPORT_NONFATAL(nft));
	rc_cfg_model rc_cfg_model_inst (.i_clk(clk), .i_ack(ack), .i_hit(hit),
		.i_rdata(rdata), .o_req(req));
	// ==========
	// Helpers
	function automatic logic [31:0] nxt(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction : nxt
	function automatic logic [31:0] ew(input logic [8:0] v, input logic c);
		ew = '0;
		for (int k = 0; k < 9; k++)
			ew[pos[k]] = v[8-k] && (k != 1 || c);
	endfunction : ew
	task automatic chk(input string n, input logic [31:0] s, x);
		n_checks++;
		if (s !== x) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", n, x, s);
		end
	endtask : chk
	task automatic close_out;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : close_out
	task automatic rdc(input logic [11:0] a, input logic [31:0] x);
		rc_cfg_model_inst.xfer(1'b0, a, 32'h0, 0, rd, ah);
		chk("ack hit", 32'(ah), {30'h1, a[11:4] == 8'h10});
		chk($sformatf("read %h", a), rd, x);
	endtask : rdc
	task automatic wrt(input logic [11:0] a, input logic [31:0] d);
		rc_cfg_model_inst.xfer(1'b1, a, d, 0, rd, ah);
		chk("write ack hit", 32'(ah), {30'h1, a[11:4] == 8'h10});
		chk("write data", rd, ZERO_WORD);
	endtask : wrt
	// Pulses events for one cycle, then checks reports, log and clearing.
	task automatic hit_ev(input logic [8:0] v, input logic [31:0] mk);
		@(negedge clk);
		ev = err_events_t'(v);
		@(negedge clk);
		ev = '0;
		e = ew(v, cap) & ~mk;
		chk("fatal", 32'(fat), 32'(|(e & sv)));
		chk("nonfatal", 32'(nft), 32'(|(e & ~sv)));
		rdc(OFS_UE_STATUS, e);
		wrt(OFS_UE_STATUS, nxt(lf));
		rdc(OFS_UE_STATUS, e & ~nxt(lf));
		wrt(OFS_UE_STATUS, 32'hffff_ffff);
	endtask : hit_ev
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			mismatches++;
			close_out();
		end
	end
	// ==========
	// Sequence
	initial begin
		repeat (8) @(negedge clk);
		rst_n = 1'b1;
		repeat (4) @(negedge clk);
		rdc(OFS_CAP_HEADER, hdr0);
		rdc(OFS_UE_STATUS, STATUS_RESET);
		rdc(OFS_UE_MASK, MASK_RESET);
		rdc(OFS_UE_SEVER, SEVER_RESET);
		rdc(12'h110, ZERO_WORD);
		wrt(OFS_CAP_HEADER, 32'hffff_ffff);
		rdc(OFS_CAP_HEADER, hdr0);
		unl = 1'b1;
		wrt(OFS_CAP_HEADER, ZERO_WORD);
		rdc(OFS_CAP_HEADER, {12'h000, hdr0[19:0]});
		unl = 1'b0;
		for (int k = 0; k < 9; k++)
			hit_ev(9'(9'h100 >> k), ZERO_WORD);
		cap = 1'b0;
		hit_ev(9'h080, ZERO_WORD);
		for (int i = 0; i < 12; i++) begin
			lf = nxt(lf);
			cap = lf[8];
			wrt(OFS_UE_MASK, lf);
			rdc(OFS_UE_MASK, lf & IMPL_BITS);
			sv = nxt(lf) & IMPL_BITS;
			wrt(OFS_UE_SEVER, nxt(lf));
			hit_ev(lf[28:20], lf);
		end
		close_out();
	end
endmodule : tb_aer_uncorrectable_error_log

// *** src/aer_pkg.sv ***
// Constants and types for the uncorrectable error log register block.
// Assumes a single core clock and configuration accesses by dword.
package aer_pkg;

	// ==========================================================
	// Register offsets
	localparam logic [11:0] OFS_CAP_HEADER = 12'h100;
	localparam logic [11:0] OFS_UE_STATUS  = 12'h104;
	localparam logic [11:0] OFS_UE_MASK    = 12'h108;
	localparam logic [11:0] OFS_UE_SEVER   = 12'h10c;

	// ==========================================================
	// Header fields
	localparam int          CAP_ID_LSB      = 0;
	localparam int          CAP_VER_LSB     = 16;
	localparam int          NEXT_PTR_LSB    = 20;
	localparam logic [15:0] CAP_ID_VALUE    = 16'h0001;
	localparam logic [3:0]  CAP_VER_VALUE   = 4'h1;
	localparam logic [11:0] NEXT_PTR_RESET  = 12'h200;

	// ==========================================================
	// Error bit positions
	localparam int BIT_OBSOLETE    = 0;
	localparam int BIT_LINK_PROTO  = 4;
	localparam int BIT_SURPRISE    = 5;
	localparam int BIT_POISONED    = 12;
	localparam int BIT_CREDIT      = 13;
	localparam int BIT_CPL_TIMEOUT = 14;
	localparam int BIT_CPL_ABORT   = 15;
	localparam int BIT_UNEXP_CPL   = 16;
	localparam int BIT_RX_OVERFLOW = 17;
	localparam int BIT_BAD_FORMAT  = 18;
	localparam int BIT_ECRC        = 19;
	localparam int BIT_UNSUPPORTED = 20;

	// Bits with storage in status, mask and severity.
	localparam logic [31:0] IMPL_BITS    = 32'h001f_3031;
	localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
	localparam logic [31:0] MASK_RESET   = 32'h0000_0000;
	localparam logic [31:0] SEVER_RESET  = 32'h0000_2030;
	localparam logic [31:0] ZERO_WORD    = 32'h0000_0000;

	// ==========================================================
	// Types
	typedef struct packed {
		logic link_proto;
		logic surprise_down;
		logic poisoned;
		logic credit_proto;
		logic unexp_cpl;
		logic rx_overflow;
		logic bad_format;
		logic ecrc;
		logic unsupported;
	} err_events_t;

	typedef struct packed {
		logic        req;
		logic        wr;
		logic [11:0] addr;
		logic [3:0]  be;
		logic [31:0] wdata;
	} cfg_req_t;

	typedef struct packed {
		logic        ack;
		logic        hit;
		logic [31:0] rdata;
	} cfg_rsp_t;

endpackage : aer_pkg

// *** src/aer_uncorrectable_error_log.sv ***
// Uncorrectable error log of one switch port: header, status, mask
// and severity registers reached by configuration requests.
// Assumes requests and error events are synchronous to I_CORE_CLK and
// that I_RST_N is the fundamental reset.
`timescale 1ns/1ps

// Contract
// R1 - Header bits 15:0 read capability id 0x1.
// R2 - Header bits 19:16 read version 0x1.
// R3 - Bit 0 obsolete, resets zero, no effect.
// R4 - Status bit 4 sets on link protocol error.
// R5 - Bit 5 surprise down, zero unless capable.
// R6 - Status bit 12 sets on poisoned TLP.
// R7 - Status bit 13 sets on credit protocol error.
// R8 - Bit 14 completion timeout reads zero always.
// R9 - Bit 15 completer abort reads zero always.
// R10 - Status bit 16 sets on unexpected completion.
// R11 - Status bit 17 sets on receive overflow.
// R12 - Status bit 18 sets on malformed TLP.
// R13 - Status bit 19 sets on ECRC error.
// R14 - Status bit 20 sets on unsupported request.
// R15 - Masked errors neither logged nor reported; zero reset.
// R16 - Severity picks fatal or non-fatal report.
// R17 - Write one clears status; sticky across soft resets.
// R18 - Reserved bits read zero, ignore writes.
module aer_uncorrectable_error_log
	import aer_pkg::*;
(
	input  wire logic        I_CORE_CLK,
	input  wire logic        I_RST_N,
	input  wire cfg_req_t    I_CFG_REQ,
	input  wire err_events_t I_ERR_EVENTS,
	input  wire logic        I_SURPRISE_LOSS_REPORT_CAPABLE,
	input  wire logic        I_NEXT_PTR_UNLOCK,
	output logic             O_CFG_ACK,
	output logic             O_CFG_HIT,
	output logic [31:0]      O_CFG_RDATA,
	output logic             O_REPORT_FATAL,
	output logic             O_REPORT_NONFATAL
);

	// ==========================================================
	// Reset synchroniser
	// Reset takes effect at once, but its release waits two edges. No
	// register can then leave reset on an edge that the release disturbs.
	logic rst_meta_ff;
	logic rst_sync_ff;

	always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			rst_meta_ff <= 1'b0;
			rst_sync_ff <= 1'b0;
		end else begin
			rst_meta_ff <= 1'b1;
			rst_sync_ff <= rst_meta_ff;
		end
	end

	// ==========================================================
	// Helpers

	// Expands byte enables into a bit mask.
	function automatic logic [31:0] be_bits(input logic [3:0] be);
		be_bits = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
	endfunction : be_bits

	// Merges written bytes into a stored word, implemented bits only.
	function automatic logic [31:0] merge_rw(input logic [31:0] cur,
		input logic [31:0] wdata, input logic [3:0] be);
		logic [31:0] sel;
		sel      = be_bits(be) & IMPL_BITS;
		merge_rw = (cur & ~sel) | (wdata & sel);
	endfunction : merge_rw

	// Clears the stored bits that a write of ones selects.
	function automatic logic [31:0] w1c_clear(input logic [31:0] cur,
		input logic [31:0] wdata, input logic [3:0] be);
		w1c_clear = cur & ~(wdata & be_bits(be));
	endfunction : w1c_clear

	// Tells whether this cycle carries a request for the given offset.
	function automatic logic addr_is(input cfg_req_t req,
		input logic [11:0] ofs);
		addr_is = req.req && (req.addr == ofs);
	endfunction : addr_is

	// Tells whether any bit of a word is set.
	function automatic logic any_bit(input logic [31:0] word);
		any_bit = |word;
	endfunction : any_bit

	// ==========================================================
	// Request decode
	logic        sel_header;
	logic        sel_status;
	logic        sel_mask;
	logic        sel_sever;
	logic        rd_cycle;
	logic [31:0] wr_sel;

	assign sel_header = addr_is(I_CFG_REQ, OFS_CAP_HEADER);
	assign sel_status = addr_is(I_CFG_REQ, OFS_UE_STATUS);
	assign sel_mask   = addr_is(I_CFG_REQ, OFS_UE_MASK);
	assign sel_sever  = addr_is(I_CFG_REQ, OFS_UE_SEVER);
	assign rd_cycle   = I_CFG_REQ.req & ~I_CFG_REQ.wr;
	assign wr_sel     = be_bits(I_CFG_REQ.be);

	// ==========================================================
	// Event mapping
	// Surprise down counts only on a port that can report it, so a port
	// without that capability neither logs nor reports the event.
	logic [31:0] evt_vec;

	always_comb begin
		evt_vec                  = ZERO_WORD;
		evt_vec[BIT_LINK_PROTO]  = I_ERR_EVENTS.link_proto;   // see R4
		evt_vec[BIT_SURPRISE]    = I_ERR_EVENTS.surprise_down
			& I_SURPRISE_LOSS_REPORT_CAPABLE;                  // see R5
		evt_vec[BIT_POISONED]    = I_ERR_EVENTS.poisoned;     // see R6
		evt_vec[BIT_CREDIT]      = I_ERR_EVENTS.credit_proto; // see R7
		evt_vec[BIT_UNEXP_CPL]   = I_ERR_EVENTS.unexp_cpl;    // see R10
		evt_vec[BIT_RX_OVERFLOW] = I_ERR_EVENTS.rx_overflow;  // see R11
		evt_vec[BIT_BAD_FORMAT]  = I_ERR_EVENTS.bad_format;   // see R12
		evt_vec[BIT_ECRC]        = I_ERR_EVENTS.ecrc;         // see R13
		evt_vec[BIT_UNSUPPORTED] = I_ERR_EVENTS.unsupported;  // see R14
	end

	// ==========================================================
	// Register state
	logic [31:0] status_ff;
	logic [31:0] mask_ff;
	logic [31:0] sever_ff;
	logic [11:0] next_ptr_ff;
	logic        wr_cycle;
	logic [31:0] unmasked_evt;
	logic [31:0] nxt_status;

	assign wr_cycle     = I_CFG_REQ.req & I_CFG_REQ.wr;
	assign unmasked_evt = evt_vec & ~mask_ff & IMPL_BITS;   // see R15

	// Status bits are sticky: only the fundamental reset or a write of one
	// clears them, and a new event wins over a clear in the same cycle.
	always_comb begin
		nxt_status = status_ff;
		if (wr_cycle && sel_status) begin
			nxt_status = w1c_clear(status_ff, I_CFG_REQ.wdata,
				I_CFG_REQ.be);                               // see R17
		end
		nxt_status = (nxt_status | unmasked_evt) & IMPL_BITS;  // see R18
	end

	// Bit 0 never has a hardware source, so it only ever reads zero.
	always_ff @(posedge I_CORE_CLK or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			status_ff <= STATUS_RESET;                       // see R3
		end else begin
			status_ff <= nxt_status;
		end
	end

	always_ff @(posedge I_CORE_CLK or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			mask_ff <= MASK_RESET;                           // see R15
		end else if (wr_cycle && sel_mask) begin
			mask_ff <= merge_rw(mask_ff, I_CFG_REQ.wdata,
				I_CFG_REQ.be);                               // see R8
		end
	end

	always_ff @(posedge I_CORE_CLK or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			sever_ff <= SEVER_RESET;                         // see R16
		end else if (wr_cycle && sel_sever) begin
			sever_ff <= merge_rw(sever_ff, I_CFG_REQ.wdata,
				I_CFG_REQ.be);                               // see R9
		end
	end

	// The next pointer is writable only while the unlock input is high.
	always_ff @(posedge I_CORE_CLK or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			next_ptr_ff <= NEXT_PTR_RESET;
		end else if (wr_cycle && I_NEXT_PTR_UNLOCK && sel_header) begin
			next_ptr_ff <= (next_ptr_ff & ~wr_sel[NEXT_PTR_LSB +: 12])
				| (I_CFG_REQ.wdata[NEXT_PTR_LSB +: 12]
				& wr_sel[NEXT_PTR_LSB +: 12]);
		end
	end

	// ==========================================================
	// Read path
	logic [31:0] rd_word;
	logic        rd_hit;

	always_comb begin
		rd_word = ZERO_WORD;
		rd_hit  = 1'b1;
		case (I_CFG_REQ.addr)
			OFS_CAP_HEADER: begin
				rd_word[CAP_ID_LSB +: 16]  = CAP_ID_VALUE;   // see R1
				rd_word[CAP_VER_LSB +: 4]  = CAP_VER_VALUE;  // see R2
				rd_word[NEXT_PTR_LSB +: 12] = next_ptr_ff;
			end
			OFS_UE_STATUS: rd_word = status_ff & IMPL_BITS;  // see R18
			OFS_UE_MASK:   rd_word = mask_ff & IMPL_BITS;
			OFS_UE_SEVER:  rd_word = sever_ff & IMPL_BITS;
			default:       rd_hit  = 1'b0;
		endcase
	end

	// Every request is answered on the next edge, mapped or not.
	always_ff @(posedge I_CORE_CLK or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			O_CFG_ACK <= 1'b0;
		end else begin
			O_CFG_ACK <= I_CFG_REQ.req;
		end
	end

	// Hit tells the requester that the offset belongs to this block.
	always_ff @(posedge I_CORE_CLK or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			O_CFG_HIT <= 1'b0;
		end else begin
			O_CFG_HIT <= I_CFG_REQ.req & rd_hit;             // see R18
		end
	end

	// Writes and unmapped reads return a zero word.
	always_ff @(posedge I_CORE_CLK or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			O_CFG_RDATA <= ZERO_WORD;
		end else if (rd_cycle) begin
			O_CFG_RDATA <= rd_word;
		end else begin
			O_CFG_RDATA <= ZERO_WORD;
		end
	end

	// ==========================================================
	// Error reporting
	logic [31:0] fatal_evt;
	logic [31:0] nonfatal_evt;

	assign fatal_evt    = unmasked_evt & sever_ff;              // see R16
	assign nonfatal_evt = unmasked_evt & ~sever_ff;             // see R16

	// One pulse per cycle and class, however many events coincide.
	always_ff @(posedge I_CORE_CLK or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			O_REPORT_FATAL <= 1'b0;
		end else begin
			O_REPORT_FATAL <= any_bit(fatal_evt);
		end
	end

	always_ff @(posedge I_CORE_CLK or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			O_REPORT_NONFATAL <= 1'b0;
		end else begin
			O_REPORT_NONFATAL <= any_bit(nonfatal_evt);     // see R15
		end
	end

endmodule : aer_uncorrectable_error_log
